/* include/sep_pkg.sv */
// Constants, register map and state encodings of the serial EEPROM port.
// Assumes a single 200 MHz APB clock and pins that arrive asynchronously.
package sep_pkg;
  // APB map
  localparam int APB_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_OPCOUNT = 4'h8;
  localparam int CTRL_LINK_EN = 0;
  localparam logic CTRL_LINK_EN_RST = 1'b1;
  localparam int ST_PROG_EN = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_STRAP_X8 = 2;
  localparam int ST_SELECTED = 3;
  localparam int ST_POLLING = 4;
  // Pin positions in the synchroniser
  localparam int PIN_N = 4;
  localparam int PIN_SEL = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_STRAP = 3;
  // Open strap reads as pulled up
  localparam logic [PIN_N-1:0] PIN_RST = 4'h8;
  // Array and instruction format
  localparam int MEM_BYTES = 128;
  localparam int OPC_W = 2;
  localparam int AW16 = 6;
  localparam int AW8 = 7;
  localparam logic [4:0] HDR16_LAST = 5'(OPC_W + AW16 - 1);
  localparam logic [4:0] HDR8_LAST = 5'(OPC_W + AW8 - 1);
  localparam logic [4:0] DAT16_LAST = 5'h0F;
  localparam logic [4:0] DAT8_LAST = 5'h07;
  localparam logic [1:0] OPC_SPECIAL = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Self-timed programming
  localparam longint PROG_TIME_MS = 10;
  localparam longint CLK_PERIOD_PS = 5000;
  localparam int PROG_CYCLES_DEF =
    int'(PROG_TIME_MS * 64'd1000000000 / CLK_PERIOD_PS);

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_HDR = 5'b00010,
    S_DIN = 5'b00100,
    S_DOUT = 5'b01000,
    S_DONE = 5'b10000
  } sep_state_e;

  typedef enum logic [4:0] {
    OP_NONE = 5'b00001,
    OP_ERASE = 5'b00010,
    OP_WRITE = 5'b00100,
    OP_CLEAR = 5'b01000,
    OP_FILL = 5'b10000
  } sep_op_e;
endpackage : sep_pkg

/* include/sep_pin_if.sv */
// Filtered pin levels and their edge pulses, synchroniser to port logic.
// Assumes both ends run on the same pclk.
`timescale 1ns/10ps
interface sep_pin_if #(parameter int N = 4);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport sync (output level, output rise, output fall);
  modport user (input level, input rise, input fall);
endinterface : sep_pin_if

/* hdl/sep_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes raw inputs are asynchronous to pclk.
`timescale 1ns/10ps
module sep_pin_sync #(
  parameter int N = 4,
  parameter logic [N-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] raw,
  sep_pin_if.sync pins
);
  for (genvar i = 0; i < N; i++) begin : g_pin
    logic [2:0] sh;
    logic filt;
    logic rise_q;
    logic fall_q;
    // Only the second and third stages vote; the first settles metastability
    wire agree = sh[1] == sh[2];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sh <= {3{RST[i]}};
        filt <= RST[i];
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end else begin
        sh <= {sh[1:0], raw[i]};
        if (agree) begin
          filt <= sh[1];
        end
        rise_q <= agree & sh[1] & ~filt;
        fall_q <= agree & ~sh[1] & filt;
      end
    end
    assign pins.level[i] = filt;
    assign pins.rise[i] = rise_q;
    assign pins.fall[i] = fall_q;
  end
endmodule : sep_pin_sync

/* hdl/sep_eeprom_port.sv */
// Serial EEPROM command port with its array, behind an APB status slave.
// Assumes shift clock far slower than pclk; pins are asynchronous.
`timescale 1ns/10ps
module sep_eeprom_port
  import sep_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic select,
  input wire logic shift_clock,
  input wire logic serial_input,
  input wire logic width_strap,
  output logic serial_out,
  output logic serial_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning

  sep_pin_if #(.N(PIN_N)) pins ();

  sep_pin_sync #(.N(PIN_N), .RST(PIN_RST)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({width_strap, serial_input, shift_clock, select}),
    .pins(pins)
  );

  logic link_en;
  logic sel_q;
  sep_state_e st;
  sep_op_e cmd_q;
  sep_op_e op_q;
  logic [4:0] cnt;
  logic [7:0] hdr_q;
  logic [15:0] din_q;
  logic [15:0] rd_q;
  logic [6:0] addr_q;
  logic strap_x8;
  logic prog_en;
  logic busy;
  logic poll;
  logic rel;
  logic [31:0] bcnt;
  logic [31:0] opcount;
  logic [6:0] p_addr;
  logic [15:0] p_data;
  logic p_x8;
  logic [7:0] mem [MEM_BYTES];

  // Link disable from software looks like a deselect
  wire sel_act = pins.level[PIN_SEL] & link_en;
  wire sel_fall = sel_q & ~sel_act;
  wire sclk_rise = sel_act & pins.rise[PIN_SCLK];
  wire sclk_fall = sel_act & pins.fall[PIN_SCLK];
  wire si = pins.level[PIN_SI];
  wire x8_now = ~pins.level[PIN_STRAP];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  wire [8:0] hdr_full = {hdr_q, si};
  wire [4:0] hdr_last_n = strap_x8 ? HDR8_LAST : HDR16_LAST;
  wire [4:0] dat_last_n = strap_x8 ? DAT8_LAST : DAT16_LAST;
  wire hdr_last = cnt == hdr_last_n;
  wire dat_last = cnt == dat_last_n;
  wire [1:0] opc = strap_x8 ? hdr_full[8:7] : hdr_full[7:6];
  wire [6:0] waddr = strap_x8 ? hdr_full[6:0] : {1'b0, hdr_full[5:0]};
  wire [1:0] sub = strap_x8 ? hdr_full[6:5] : hdr_full[5:4];
  wire dec_now = sclk_rise & (st == S_HDR) & hdr_last;
  wire start_bit = sclk_rise & si & ~busy & (st == S_IDLE);

  wire is_read = opc == OPC_READ;
  wire is_special = opc == OPC_SPECIAL;
  wire is_fill = is_special & (sub == SUB_FILL);
  wire is_clear = is_special & (sub == SUB_CLEAR);

  // Command kept only while unlocked; locked commands leave the array alone
  sep_op_e dec_op;
  always_comb begin
    dec_op = OP_NONE;
    if (prog_en) begin
      case (opc)
        OPC_ERASE: dec_op = OP_ERASE;
        OPC_WRITE: dec_op = OP_WRITE;
        default: begin
          if (is_clear) begin
            dec_op = OP_CLEAR;
          end else if (is_fill) begin
            dec_op = OP_FILL;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= sel_act;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;
      cnt <= 5'h00;
      hdr_q <= 8'h00;
      din_q <= 16'h0000;
      addr_q <= 7'h00;
      strap_x8 <= 1'b0;
      cmd_q <= OP_NONE;
    end else if (!sel_act) begin
      // Partial instruction is dropped on deselect
      st <= S_IDLE;
      cnt <= 5'h00;
      cmd_q <= OP_NONE;
    end else if (sclk_rise) begin
      case (st)
        S_IDLE: begin
          // Busy array ignores new work; polling still works
          if (si && !busy) begin
            st <= S_HDR;
            cnt <= 5'h00;
            strap_x8 <= x8_now;
          end
        end
        S_HDR: begin
          hdr_q <= hdr_full[7:0];
          cnt <= cnt + 5'h01;
          if (hdr_last) begin
            addr_q <= waddr;
            cmd_q <= dec_op;
            cnt <= 5'h00;
            if (is_read) begin
              st <= S_DOUT;
            end else if (opc == OPC_WRITE || is_fill) begin
              st <= S_DIN;
            end else begin
              st <= S_DONE;
            end
          end
        end
        S_DIN: begin
          din_q <= {din_q[14:0], si};
          cnt <= cnt + 5'h01;
          if (dat_last) begin
            st <= S_DONE;
          end
        end
        S_DOUT: begin
          cnt <= cnt + 5'h01;
          if (dat_last) begin
            st <= S_DONE;
          end
        end
        S_DONE: begin
          st <= S_DONE;
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming lock

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_en <= 1'b0;
    end else if (dec_now && is_special && sub == SUB_UNLOCK) begin
      prog_en <= 1'b1;
    end else if (dec_now && is_special && sub == SUB_LOCK) begin
      prog_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed cycle

  // Launch only for a complete instruction, on the deselecting edge
  wire launch = sel_fall & (st == S_DONE) & (cmd_q != OP_NONE);
  wire prog_done = busy & (bcnt == 32'(PROG_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      bcnt <= 32'h0000_0000;
      op_q <= OP_NONE;
      p_addr <= 7'h00;
      p_data <= 16'h0000;
      p_x8 <= 1'b0;
    end else if (launch) begin
      busy <= 1'b1;
      bcnt <= 32'h0000_0000;
      op_q <= cmd_q;
      p_addr <= addr_q;
      p_data <= din_q;
      p_x8 <= strap_x8;
    end else if (busy) begin
      // Runs from pclk alone, shift clock not needed
      bcnt <= bcnt + 32'h0000_0001;
      if (prog_done) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcount <= 32'h0000_0000;
    end else if (prog_done) begin
      opcount <= opcount + 32'h0000_0001;
    end
  end

  // Byte lane of a word: even byte holds the upper half in 64x16
  function automatic logic byte_hit(input int idx, input logic [6:0] a,
                                    input logic x8);
    logic [6:0] i7;
    i7 = 7'(idx);
    byte_hit = x8 ? (i7 == a) : (i7[6:1] == a[5:0]);
  endfunction : byte_hit

  function automatic logic [7:0] byte_of(input int idx,
                                         input logic [15:0] d,
                                         input logic x8);
    logic [6:0] i7;
    i7 = 7'(idx);
    byte_of = (x8 || i7[0]) ? d[7:0] : d[15:8];
  endfunction : byte_of

  // Array updated at the end of the cycle; erase leaves all ones
  always_ff @(posedge pclk) begin
    if (prog_done) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        case (op_q)
          OP_ERASE: begin
            if (byte_hit(i, p_addr, p_x8)) begin
              mem[i] <= ERASED_BYTE;
            end
          end
          OP_WRITE: begin
            // Built-in erase, so old contents do not matter
            if (byte_hit(i, p_addr, p_x8)) begin
              mem[i] <= byte_of(i, p_data, p_x8);
            end
          end
          OP_CLEAR: mem[i] <= ERASED_BYTE;
          // Fill only pulls bits low; unerased cells keep their zeros
          OP_FILL: mem[i] <= mem[i] & byte_of(i, p_data, p_x8);
          default: mem[i] <= mem[i];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output

  wire [7:0] rd_hi = mem[{waddr[5:0], 1'b0}];
  wire [7:0] rd_lo = mem[{waddr[5:0], 1'b1}];
  wire [15:0] rd_word = strap_x8 ? {mem[waddr], 8'h00} : {rd_hi, rd_lo};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll <= 1'b0;
    end else if (launch) begin
      poll <= 1'b1;
    end else if (start_bit) begin
      poll <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_oe <= 1'b0;
      serial_out <= 1'b0;
      rd_q <= 16'h0000;
      rel <= 1'b0;
    end else if (!sel_act) begin
      serial_oe <= 1'b0;
      rel <= 1'b0;
    end else if (rel && sclk_fall) begin
      // Stays released until deselect or a read takes the line
      serial_oe <= 1'b0;
    end else if (dec_now && is_read) begin
      serial_oe <= 1'b1;
      serial_out <= 1'b0;
      rd_q <= rd_word;
      rel <= 1'b0;
    end else if (st == S_DOUT && sclk_rise) begin
      serial_out <= rd_q[15];
      rd_q <= {rd_q[14:0], 1'b0};
    end else if (poll && st == S_IDLE && !rel) begin
      serial_oe <= 1'b1;
      serial_out <= ~busy;
      if (sclk_rise && si) begin
        rel <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire hit_ctrl = paddr == REG_CTRL;
  wire hit_stat = paddr == REG_STATUS;
  wire hit_cnt = paddr == REG_OPCOUNT;
  wire hit_any = hit_ctrl | hit_stat | hit_cnt;

  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ST_PROG_EN] = prog_en;
    stat_word[ST_BUSY] = busy;
    stat_word[ST_STRAP_X8] = x8_now;
    stat_word[ST_SELECTED] = sel_act;
    stat_word[ST_POLLING] = poll;
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[CTRL_LINK_EN] = link_en;
    end else if (hit_stat) begin
      rd_mux = stat_word;
    end else if (hit_cnt) begin
      rd_mux = opcount;
    end
  end

  // Answer in the first access cycle: no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~hit_any;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_en <= CTRL_LINK_EN_RST;
    end else if (apb_done && pwrite && hit_ctrl) begin
      link_en <= pwdata[CTRL_LINK_EN];
    end
  end

endmodule : sep_eeprom_port

/* bench/sep_eeprom_port_assertions.sv */
// Concurrent checks on the APB answer and the serial data-out pin.
// Assumes binding to sep_eeprom_port; pins are slow and asynchronous.
`timescale 1ns/10ps
module sep_eeprom_port_assertions
  import sep_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic select,
  input wire logic shift_clock,
  input wire logic serial_input,
  input wire logic width_strap,
  input wire logic serial_out,
  input wire logic serial_oe
);
  logic [3:0] desel_cnt;
  wire logic setup = psel && !penable;
  wire logic mapped = paddr inside {REG_CTRL, REG_STATUS, REG_OPCOUNT};
  // Saturates so a long idle stays checked
  wire logic [3:0] next_desel_cnt = select ? 4'h0 :
    (desel_cnt == 4'hF) ? desel_cnt : desel_cnt + 4'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) desel_cnt <= 4'h0;
    else desel_cnt <= next_desel_cnt;
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no pready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
  property p_unmapped; setup && !mapped |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_mapped; setup && mapped |=> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_wr_zero; setup && pwrite |=> prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("prdata on write");
  property p_float; desel_cnt == 4'hF |-> !serial_oe; endproperty
  a_float: assert property (p_float) else $error("driven when idle");
  property p_oe_sel; $rose(serial_oe) |-> select; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("oe without select");
  property p_release; $fell(serial_oe) |-> !select || !shift_clock;
  endproperty
  a_release: assert property (p_release) else $error("early release");
  property p_out_rise;
    $fell(serial_out) && $past(serial_oe) && serial_oe |-> shift_clock;
  endproperty
  a_out_rise: assert property (p_out_rise) else $error("out off edge");
  c_read: cover property (serial_oe && shift_clock && select);
  c_err: cover property (pslverr);
  c_rel: cover property ($fell(serial_oe) && select);
endmodule : sep_eeprom_port_assertions

bind sep_eeprom_port sep_eeprom_port_assertions #(.PROG_CYCLES(PROG_CYCLES))
  u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .select(select),
  .shift_clock(shift_clock), .serial_input(serial_input),
  .width_strap(width_strap), .serial_out(serial_out),
  .serial_oe(serial_oe));

/* bench/sep_host_model.sv */
// Host side of the three-wire serial bus, driven task by task.
// Assumes pclk at 200 MHz; 16 pclk per shift clock half period.
`timescale 1ns/10ps
module sep_host_model (
  input wire logic pclk,
  input wire logic serial_out,
  input wire logic serial_oe,
  output logic select,
  output logic shift_clock,
  output logic serial_input
);
  logic line_last = 1'b0;
  logic line;
  // Released line shows the inverse, so a stale level never passes
  assign line = serial_oe ? serial_out : ~line_last;
  always @(posedge pclk) if (serial_oe) line_last <= serial_out;
  initial begin
    select = 1'b0;
    shift_clock = 1'b0;
    serial_input = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic bit_out(input logic b, output logic got);
    serial_input <= b;
    tick(16);
    shift_clock <= 1'b1;
    tick(16);
    got = line;
    shift_clock <= 1'b0;
  endtask : bit_out
  task automatic xfer(input logic [31:0] bits, input int n,
                      output logic [31:0] got);
    logic g;
    got = '0;
    select <= 1'b1;
    tick(4);
    for (int i = n - 1; i >= 0; i--) begin
      bit_out(bits[i], g);
      got = {got[30:0], g};
    end
    tick(16);
    serial_input <= 1'b0;
    select <= 1'b0;
    tick(200);
  endtask : xfer
  // Status poll, then a one shifted in to float the line again
  task automatic poll(output logic ready, output logic oe_left);
    logic g;
    select <= 1'b1;
    tick(8);
    ready = line;
    bit_out(1'b1, g);
    tick(8);
    oe_left = serial_oe;
    serial_input <= 1'b0;
    select <= 1'b0;
    tick(200);
  endtask : poll
endmodule : sep_host_model

/* bench/sep_testbench.sv */
// Self-checking bench: APB register access plus serial commands.
// Assumes the host model drives the pins; programming time is shortened.
`timescale 1ns/10ps
module testbench
  import sep_pkg::*;
;
  localparam int PROG = 1000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, select, shift_clock, serial_input, serial_out;
  logic serial_oe;
  logic width_strap = 1'b1;
  logic x8 = 1'b0;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ops = 0;
  always #2.5 pclk = ~pclk;
  sep_eeprom_port #(.PROG_CYCLES(PROG)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .select(select), .shift_clock(shift_clock),
    .serial_input(serial_input), .width_strap(width_strap),
    .serial_out(serial_out), .serial_oe(serial_oe));
  sep_host_model u_host (.pclk(pclk), .serial_out(serial_out),
    .serial_oe(serial_oe), .select(select), .shift_clock(shift_clock),
    .serial_input(serial_input));
  //////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 100000) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    check({31'h0, pslverr}, {31'h0, !(a inside {4'h0, 4'h4, 4'h8})});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r & (a == REG_STATUS ? 32'hF : 32'hFFFFFFFF), exp);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic cmd(input logic [1:0] op, input logic [6:0] a,
                     input logic [15:0] d, output logic [31:0] got);
    logic [31:0] bits;
    logic dat;
    int n;
    dat = (op[1] ^ op[0]) || (op == OPC_SPECIAL &&
      (x8 ? a[6:5] : a[5:4]) == SUB_FILL);
    if (x8) bits = {14'h0, 1'b1, op, a, d[7:0]};
    else bits = {7'h0, 1'b1, op, a[5:0], d};
    n = dat ? (x8 ? 18 : 25) : (x8 ? 10 : 9);
    if (!dat) bits = bits >> (x8 ? 8 : 16);
    u_host.xfer(bits, n, got);
  endtask : cmd
  task automatic sp(input logic [1:0] sub, input logic [15:0] d);
    logic [31:0] g;
    cmd(OPC_SPECIAL, x8 ? {sub, 5'h0} : {1'b0, sub, 4'h0}, d, g);
  endtask : sp
  task automatic rdw(input logic [6:0] a, input logic [15:0] exp);
    logic [31:0] g;
    cmd(OPC_READ, a, 16'h0, g);
    if (x8) check({23'h0, g[8:0]}, {23'h0, 1'b0, exp[7:0]});
    else check({15'h0, g[16:0]}, {15'h0, 1'b0, exp});
  endtask : rdw
  task automatic settle(input logic busy_exp);
    logic rdy, oel;
    int k;
    u_host.poll(rdy, oel);
    check({31'h0, rdy}, {31'h0, !busy_exp});
    check({31'h0, oel}, 32'h0);
    for (k = 0; k < 8 && rdy !== 1'b1; k++) u_host.poll(rdy, oel);
    check({31'h0, rdy}, 32'h1);
    if (busy_exp) ops++;
    rd(REG_OPCOUNT, ops);
  endtask : settle
  //////////////////////////////////////////////////////////////////////
  logic [31:0] g;
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(REG_CTRL, 32'h1);
    rd(REG_STATUS, 32'h0);
    rd(4'hC, 32'h0);
    wr(REG_STATUS, 32'hFF);
    rd(REG_STATUS, 32'h0);
    wr(REG_CTRL, 32'h0);
    rd(REG_CTRL, 32'h0);
    wr(REG_CTRL, 32'h1);
    sp(SUB_CLEAR, 16'h0);
    settle(1'b0);
    sp(SUB_UNLOCK, 16'h0);
    rd(REG_STATUS, 32'h1);
    sp(SUB_CLEAR, 16'h0);
    settle(1'b1);
    rdw(7'h05, 16'hFFFF);
    cmd(OPC_WRITE, 7'h05, 16'hA5C3, g);
    settle(1'b1);
    rdw(7'h05, 16'hA5C3);
    cmd(OPC_WRITE, 7'h05, 16'h1234, g);
    settle(1'b1);
    rdw(7'h05, 16'h1234);
    rdw(7'h06, 16'hFFFF);
    cmd(OPC_ERASE, 7'h05, 16'h0, g);
    settle(1'b1);
    rdw(7'h05, 16'hFFFF);
    width_strap <= 1'b0;
    x8 = 1'b1;
    // Strap passes the pin filter before status shows it
    repeat (8) @(posedge pclk);
    rd(REG_STATUS, 32'h5);
    cmd(OPC_WRITE, 7'h0B, 16'h005A, g);
    settle(1'b1);
    rdw(7'h0B, 16'h005A);
    rdw(7'h0A, 16'h00FF);
    sp(SUB_CLEAR, 16'h0);
    settle(1'b1);
    sp(SUB_FILL, 16'h003C);
    settle(1'b1);
    rdw(7'h7F, 16'h003C);
    width_strap <= 1'b1;
    x8 = 1'b0;
    rdw(7'h3F, 16'h3C3C);
    wr(REG_CTRL, 32'h0);
    sp(SUB_LOCK, 16'h0);
    rd(REG_STATUS, 32'h1);
    wr(REG_CTRL, 32'h1);
    sp(SUB_LOCK, 16'h0);
    rd(REG_STATUS, 32'h0);
    cmd(OPC_WRITE, 7'h3F, 16'h0000, g);
    settle(1'b0);
    rdw(7'h3F, 16'h3C3C);
    print_verdict();
  end
endmodule : testbench
